// file: logic/spb_pkg.sv
/*
 * Shared constants, frame helpers and host register map for the serial
 * port bridge (device end, host end, link carrier).
 * Assumes one 250 MHz system clock on both ends and a mode-0 serial link.
 */
package spb_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int          FRAME_BITS   = 16;
	localparam int          ADDR_W       = 13;
	localparam logic [4:0]  FRAME_CNT    = 5'h10;
	localparam int          ST_BUS_FAULT = 0;
	localparam int          ST_CLK_FAULT = 2;
	localparam int          ST_IGNORED   = 3;
	localparam logic [15:0] RESP_RST     = 16'h2002;

	// ****************************************
	// Address windows
	// ****************************************
	localparam logic [12:0] SECURE_LO_END = 13'h008F;
	localparam logic [12:0] SECURE_HI_BEG = 13'h1800;
	localparam logic [12:0] SECURE_HI_END = 13'h188F;
	localparam logic [15:0] PORT_EN_ADDR  = 16'h1802;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS          = 4;
	localparam int SCLK_HALF_NS    = 50;
	localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUS_WAIT_CYC    = 16;
	localparam int FRAME_GAP_CYC   = 64;
	localparam int STRAP_HOLD_NS   = 1000;
	localparam int STRAP_HOLD_CYC  = (STRAP_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int STRAP_DRIVE_CYC = 2 * STRAP_HOLD_CYC;

	// ****************************************
	// Host register map
	// ****************************************
	localparam logic [7:0] HREG_ADDR   = 8'h00;
	localparam logic [7:0] HREG_WDATA  = 8'h04;
	localparam logic [7:0] HREG_CMD    = 8'h08;
	localparam logic [7:0] HREG_STAT   = 8'h0C;
	localparam int         CMD_READ    = 0;
	localparam int         CMD_WRITE   = 1;

	// ****************************************
	// Frame helpers
	// ****************************************
	// even parity append
	function automatic logic [15:0] spb_frame(input logic [13:0] body);
		return {body, ^body[13:7], ^body[6:0]};
	endfunction

	function automatic logic spb_parity_ok(input logic [15:0] f);
		return f == spb_frame(f[15:2]);
	endfunction

endpackage

// file: logic/spb_link_if.sv
/*
 * Serial link carrier between host end and device end.
 * Assumes the bench resolves the data-out wire from its enable.
 */
`timescale 1ns/100ps
interface spb_link_if;
	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic enable_strap_pin_n;

	modport dev_mp (input sclk, input ss_n, input mosi, input enable_strap_pin_n, output miso, output miso_oe);
	modport host_mp (output sclk, output ss_n, output mosi, output enable_strap_pin_n, input miso, input miso_oe);
endinterface

// file: logic/spb_sync.sv
/*
 * Two-flop level synchroniser with clock enable.
 * Assumes the input is asynchronous to ref_clk.
 */
`timescale 1ns/100ps
module spb_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// Level
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else if (clk_en) begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule

// file: logic/spb_dev.sv
/*
 * Device end: mode-0 serial slave that masters the internal bus for
 * single-byte reads and writes.
 * Assumes bus_gnt answers bus_req, and read data stand the cycle after
 * the read strobe.
 */
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module spb_dev
	import spb_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// Serial link
	spb_link_if.dev_mp       link,
	// Enable and security
	input  wire logic        serial_port_enable,
	input  wire logic [1:0]  memory_security_level,
	// Internal bus master
	output logic             bus_req,
	input  wire logic        bus_gnt,
	output logic [15:0]      bus_addr,
	output logic             bus_rd,
	output logic             bus_wr,
	output logic [7:0]       bus_wdata,
	input  wire logic [7:0]  bus_rdata,
	output logic             cpu_stall,
	// Status
	output logic             port_active,
	output logic [4:0]       last_status
);

	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_REQ  = 2'b01,
		P_XFER = 2'b11,
		P_CAP  = 2'b10
	} spb_pstate_t;

	localparam logic [3:0] SYNC_RST = 4'h2;

	// ****************************************
	// Helpers
	// ****************************************
	// reserved status bit zero
	function automatic logic [13:0] resp_body(input logic op, input logic [4:0] st, input logic [7:0] d);
		return {op, 1'b0, st[3:0], d};
	endfunction

	function automatic logic addr_blocked(input logic [1:0] lvl, input logic [12:0] a);
		return (lvl != 2'b00) && !((a <= SECURE_LO_END) || ((a >= SECURE_HI_BEG) && (a <= SECURE_HI_END)));
	endfunction

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [3:0] raw;
	logic [3:0] syn;
	logic       sclk_s;
	logic       ss_s;
	logic       mosi_s;
	logic       strap_s;

	assign raw = {link.enable_strap_pin_n, link.mosi, link.ss_n, link.sclk};

	generate
		for (genvar gi = 0; gi < 4; gi++) begin : g_sync
			spb_sync #(.RST_VAL(SYNC_RST[gi])) u_sync (
				.ref_clk  (ref_clk),
				.sys_rst  (sys_rst),
				.clk_en   (clk_en),
				.async_in (raw[gi]),
				.sync_out (syn[gi])
			);
		end
	endgenerate

	assign sclk_s  = syn[0];
	assign ss_s    = syn[1];
	assign mosi_s  = syn[2];
	assign strap_s = syn[3];

	// ****************************************
	// Edge detection
	// ****************************************
	logic sclk_d_r;
	logic ss_d_r;
	logic sclk_rise;
	logic sclk_fall;
	logic ss_fall;
	logic ss_rise;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_d_r <= 1'b0;
			ss_d_r   <= 1'b1;
		end else if (clk_en) begin
			sclk_d_r <= sclk_s;
			ss_d_r   <= ss_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign sclk_fall = ~sclk_s & sclk_d_r;
	assign ss_fall   = ~ss_s & ss_d_r;
	assign ss_rise   = ss_s & ~ss_d_r;

	// ****************************************
	// Enable
	// ****************************************
	logic [8:0] strap_cnt_r;
	logic       strap_open_r;
	logic       strap_en_r;
	logic       en_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_cnt_r  <= 9'h000;
			strap_open_r <= 1'b1;
			strap_en_r   <= 1'b0;
		end else if (clk_en && strap_open_r) begin
			if (strap_s) begin
				strap_open_r <= 1'b0;
			end else if (strap_cnt_r == 9'(STRAP_HOLD_CYC - 1)) begin
				strap_en_r   <= 1'b1;
				strap_open_r <= 1'b0;
			end else begin
				strap_cnt_r <= strap_cnt_r + 9'h001;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_r <= 1'b0;
		end else if (clk_en && ss_s) begin
			en_r <= serial_port_enable | strap_en_r;
		end
	end

	// ****************************************
	// Shifter
	// ****************************************
	logic [4:0]  bit_cnt_r;
	logic [15:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] resp_r;
	logic        miso_r;
	logic        miso_oe_r;
	logic        done_r;
	logic [4:0]  done_cnt_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt_r  <= 5'h00;
			rx_r       <= 16'h0000;
			done_r     <= 1'b0;
			done_cnt_r <= 5'h00;
		end else if (clk_en) begin
			done_r <= 1'b0;
			if (!en_r || ss_fall) begin
				bit_cnt_r <= 5'h00;
			end else if (ss_rise) begin
				done_r     <= 1'b1;
				done_cnt_r <= bit_cnt_r;
				bit_cnt_r  <= 5'h00;
			end else if (sclk_rise && !ss_s) begin
				rx_r <= {rx_r[14:0], mosi_s};
				if (bit_cnt_r != 5'h1F) begin
					bit_cnt_r <= bit_cnt_r + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_r      <= 16'h0000;
			miso_r    <= 1'b0;
			miso_oe_r <= 1'b0;
		end else if (clk_en) begin
			if (!en_r || ss_s) begin
				miso_oe_r <= 1'b0;
			end else if (ss_fall) begin
				tx_r      <= resp_r;
				miso_r    <= resp_r[15];
				miso_oe_r <= 1'b1;
			end else if (sclk_fall && bit_cnt_r != 5'h00) begin
				tx_r   <= {tx_r[14:0], 1'b0};
				miso_r <= tx_r[14];
			end
		end
	end

	// ****************************************
	// Command processing and bus master
	// ****************************************
	spb_pstate_t st_r;
	logic        pend_wr_r;
	logic        op_wr_r;
	logic [12:0] addr_r;
	logic [7:0]  wdata_r;
	logic [4:0]  wait_r;
	logic [4:0]  status_r;
	logic        bus_req_r;
	logic        bus_rd_r;
	logic        bus_wr_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r      <= P_IDLE;
			pend_wr_r <= 1'b0;
			op_wr_r   <= 1'b0;
			addr_r    <= 13'h0000;
			wdata_r   <= 8'h00;
			wait_r    <= 5'h00;
			status_r  <= 5'h08;
			resp_r    <= RESP_RST;
			bus_req_r <= 1'b0;
			bus_rd_r  <= 1'b0;
			bus_wr_r  <= 1'b0;
		end else if (clk_en) begin
			case (st_r)
				P_IDLE: begin
					if (done_r) begin
						if (done_cnt_r != FRAME_CNT || !spb_parity_ok(rx_r) || (pend_wr_r && !rx_r[15])) begin
							status_r <= {1'b0, 1'b1, (done_cnt_r != FRAME_CNT), 2'b00};
							resp_r    <= spb_frame(resp_body(resp_r[15],
								{1'b0, 1'b1, (done_cnt_r != FRAME_CNT), 2'b00}, resp_r[9:2]));
							pend_wr_r <= 1'b0;
						end else if (pend_wr_r) begin
							pend_wr_r <= 1'b0;
							op_wr_r   <= 1'b1;
							wdata_r   <= rx_r[9:2];
							if (addr_blocked(memory_security_level, addr_r)) begin
								status_r <= 5'h09;
								resp_r   <= spb_frame(resp_body(1'b1, 5'h09, rx_r[9:2]));
							end else begin
								wait_r <= 5'h00;
								st_r   <= P_REQ;
							end
						end else if (rx_r[15]) begin
							pend_wr_r <= 1'b1;
							addr_r    <= rx_r[14:2];
							resp_r    <= rx_r;
						end else begin
							op_wr_r <= 1'b0;
							addr_r  <= rx_r[14:2];
							if (addr_blocked(memory_security_level, rx_r[14:2])) begin
								status_r <= 5'h01;
								resp_r   <= spb_frame(resp_body(1'b0, 5'h01, resp_r[9:2]));
							end else begin
								wait_r <= 5'h00;
								st_r   <= P_REQ;
							end
						end
					end
				end
				P_REQ: begin
					bus_req_r <= 1'b1;
					if (bus_req_r && bus_gnt) begin
						bus_rd_r <= ~op_wr_r;
						bus_wr_r <= op_wr_r;
						st_r     <= P_XFER;
					end else if (wait_r == 5'(BUS_WAIT_CYC - 1)) begin
						bus_req_r <= 1'b0;
						status_r  <= op_wr_r ? 5'h09 : 5'h01;
						resp_r    <= spb_frame(resp_body(op_wr_r, op_wr_r ? 5'h09 : 5'h01,
							op_wr_r ? wdata_r : resp_r[9:2]));
						st_r      <= P_IDLE;
					end else begin
						wait_r <= wait_r + 5'h01;
					end
				end
				P_XFER: begin
					bus_rd_r <= 1'b0;
					bus_wr_r <= 1'b0;
					st_r     <= P_CAP;
				end
				P_CAP: begin
					bus_req_r <= 1'b0;
					status_r  <= 5'h00;
					resp_r    <= spb_frame(resp_body(op_wr_r, 5'h00, op_wr_r ? wdata_r : bus_rdata));
					st_r      <= P_IDLE;
				end
				default: begin
					st_r <= P_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic port_active_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_active_r <= 1'b0;
		end else if (clk_en) begin
			port_active_r <= en_r & ~ss_s;
		end
	end

	assign link.miso    = miso_r;
	assign link.miso_oe = miso_oe_r;
	assign bus_req      = bus_req_r;
	assign cpu_stall    = bus_req_r;
	assign bus_addr     = {3'b000, addr_r};
	assign bus_rd       = bus_rd_r;
	assign bus_wr       = bus_wr_r;
	assign bus_wdata    = wdata_r;
	assign port_active  = port_active_r;
	assign last_status  = status_r;

endmodule

// file: logic/spb_host.sv
/*
 * Host end: serial master that runs one single-byte read or write per
 * command written to its register port.
 * Assumes a 250 MHz clock; serial clock is divided from it.
 */
`timescale 1ns/100ps
module spb_host
	import spb_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Serial link
	spb_link_if.host_mp      link
);

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LOW  = 3'b001,
		H_HIGH = 3'b011,
		H_END  = 3'b010,
		H_GAP  = 3'b110
	} spb_hstate_t;

	// Frame for slot idx of a transaction
	function automatic logic [15:0] tx_frame(input logic wr, input logic [1:0] idx,
		input logic [12:0] a, input logic [7:0] d);
		if (wr && idx == 2'd1) begin
			return spb_frame({1'b1, 5'h00, d});
		end
		return spb_frame({wr && idx == 2'd0, a});
	endfunction

	logic miso_s;

	spb_sync #(.RST_VAL(1'b0)) u_miso_sync (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.async_in (link.miso),
		.sync_out (miso_s)
	);

	// ****************************************
	// Strap drive
	// ****************************************
	logic [9:0] strap_cnt_r;
	logic       strap_n_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_cnt_r <= 10'h000;
			strap_n_r   <= 1'b0;
		end else if (clk_en && !strap_n_r) begin
			if (strap_cnt_r == 10'(STRAP_DRIVE_CYC - 1)) begin
				strap_n_r <= 1'b1;
			end else begin
				strap_cnt_r <= strap_cnt_r + 10'h001;
			end
		end
	end

	// ****************************************
	// Transaction engine
	// ****************************************
	spb_hstate_t st_r;
	logic [12:0] addr_r;
	logic [7:0]  wdata_r;
	logic        wr_r;
	logic [1:0]  idx_r;
	logic [3:0]  bit_r;
	logic [6:0]  tmr_r;
	logic [15:0] sh_r;
	logic [15:0] rx_r;
	logic        sclk_r;
	logic        ss_n_r;
	logic        mosi_r;
	logic [4:0]  status_r;
	logic [7:0]  rdata_r;
	logic        perr_r;
	logic [1:0]  last_idx;
	logic        go;

	assign last_idx = wr_r ? 2'd2 : 2'd1;
	assign go       = reg_wr && reg_addr == HREG_CMD && st_r == H_IDLE;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_r  <= 13'h0000;
			wdata_r <= 8'h00;
		end else if (clk_en && reg_wr && st_r == H_IDLE) begin
			if (reg_addr == HREG_ADDR) begin
				addr_r <= reg_wdata[12:0];
			end
			if (reg_addr == HREG_WDATA) begin
				wdata_r <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r     <= H_IDLE;
			wr_r     <= 1'b0;
			idx_r    <= 2'd0;
			bit_r    <= 4'h0;
			tmr_r    <= 7'h00;
			sh_r     <= 16'h0000;
			rx_r     <= 16'h0000;
			sclk_r   <= 1'b0;
			ss_n_r   <= 1'b1;
			mosi_r   <= 1'b0;
			status_r <= 5'h00;
			rdata_r  <= 8'h00;
			perr_r   <= 1'b0;
		end else if (clk_en) begin
			case (st_r)
				H_IDLE: begin
					if (go && (reg_wdata[CMD_READ] || reg_wdata[CMD_WRITE])) begin
						wr_r   <= reg_wdata[CMD_WRITE];
						idx_r  <= 2'd0;
						bit_r  <= 4'h0;
						tmr_r  <= 7'h00;
						sh_r   <= tx_frame(reg_wdata[CMD_WRITE], 2'd0, addr_r, wdata_r);
						mosi_r <= 1'(tx_frame(reg_wdata[CMD_WRITE], 2'd0, addr_r, wdata_r) >> 15);
						ss_n_r <= 1'b0;
						st_r   <= H_LOW;
					end
				end
				H_LOW: begin
					if (tmr_r == 7'(SCLK_HALF_CYC - 1)) begin
						sclk_r <= 1'b1;
						rx_r   <= {rx_r[14:0], miso_s};
						tmr_r  <= 7'h00;
						st_r   <= H_HIGH;
					end else begin
						tmr_r <= tmr_r + 7'h01;
					end
				end
				H_HIGH: begin
					if (tmr_r == 7'(SCLK_HALF_CYC - 1)) begin
						sclk_r <= 1'b0;
						tmr_r  <= 7'h00;
						if (bit_r == 4'hF) begin
							st_r <= H_END;
						end else begin
							bit_r  <= bit_r + 4'h1;
							sh_r   <= {sh_r[14:0], 1'b0};
							mosi_r <= sh_r[14];
							st_r   <= H_LOW;
						end
					end else begin
						tmr_r <= tmr_r + 7'h01;
					end
				end
				H_END: begin
					if (tmr_r == 7'(SCLK_HALF_CYC - 1)) begin
						ss_n_r <= 1'b1;
						tmr_r  <= 7'h00;
						st_r   <= H_GAP;
					end else begin
						tmr_r <= tmr_r + 7'h01;
					end
				end
				H_GAP: begin
					if (tmr_r == 7'(FRAME_GAP_CYC - 1)) begin
						tmr_r <= 7'h00;
						bit_r <= 4'h0;
						if (idx_r == last_idx) begin
							status_r <= rx_r[14:10];
							rdata_r  <= rx_r[9:2];
							perr_r   <= ~spb_parity_ok(rx_r);
							st_r     <= H_IDLE;
						end else begin
							idx_r  <= idx_r + 2'd1;
							sh_r   <= tx_frame(wr_r, idx_r + 2'd1, addr_r, wdata_r);
							mosi_r <= 1'(tx_frame(wr_r, idx_r + 2'd1, addr_r, wdata_r) >> 15);
							ss_n_r <= 1'b0;
							st_r   <= H_LOW;
						end
					end else begin
						tmr_r <= tmr_r + 7'h01;
					end
				end
				default: begin
					st_r <= H_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	logic [31:0] rdata_q_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q_r <= 32'h00000000;
		end else if (clk_en) begin
			rdata_q_r <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					HREG_ADDR:  rdata_q_r <= {19'h00000, addr_r};
					HREG_WDATA: rdata_q_r <= {24'h000000, wdata_r};
					HREG_STAT:  rdata_q_r <= {16'h0000, rdata_r, 1'b0, perr_r, status_r, st_r != H_IDLE};
					default:    rdata_q_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign reg_rdata               = rdata_q_r;
	assign link.sclk               = sclk_r;
	assign link.ss_n               = ss_n_r;
	assign link.mosi               = mosi_r;
	assign link.enable_strap_pin_n = strap_n_r;

endmodule

// file: verification/spb_link_assertions.sv
/*
 * Wire checks on the serial link between host end and device end.
 * Assumes plain link signals, one ref_clk domain, reset active high.
 */
`timescale 1ns/100ps
module spb_link_assertions (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Serial link
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	logic        sclk_r;
	logic [7:0]  stay_r;
	logic [4:0]  rise_r;
	logic [15:0] mo_r;
	logic [15:0] mi_r;
	logic        ss_q_r;
	logic        echo_r;
	logic [15:0] cmd_r;
	wire         rise = sclk & ~sclk_r;

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) sclk_r <= 1'b0;
		else sclk_r <= sclk;
	// Cycles since last clock edge
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) stay_r <= 8'h00;
		else if (sclk != sclk_r) stay_r <= 8'h00;
		else if (stay_r != 8'hFF) stay_r <= stay_r + 8'h01;
	// Rises per select low
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) rise_r <= 5'h00;
		else if (ss_n) rise_r <= 5'h00;
		else rise_r <= rise_r + {4'h0, rise};
	// Frame shifters
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mo_r <= 16'h0000;
			mi_r <= 16'h0000;
		end else if (rise) begin
			mo_r <= {mo_r[14:0], mosi};
			mi_r <= {mi_r[14:0], miso};
		end
	end
	// Frame after a write command carries the echo
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ss_q_r <= 1'b1;
			echo_r <= 1'b0;
			cmd_r  <= 16'h0000;
		end else begin
			ss_q_r <= ss_n;
			if (ss_n && !ss_q_r) begin
				echo_r <= !echo_r && mo_r[15];
				cmd_r  <= mo_r;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_idle_low; ss_n |-> !sclk; endproperty
	a_idle_low: assert property (p_idle_low) else $error("clock high while deselected");
	property p_mosi_hold; $rose(sclk) |-> $stable(mosi); endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at rise");
	property p_miso_hold; $rose(sclk) && miso_oe |-> $stable(miso); endproperty
	a_miso_hold: assert property (p_miso_hold) else $error("miso moved at rise");
	property p_half; !ss_n && sclk != sclk_r |-> stay_r >= 8'd12; endproperty
	a_half: assert property (p_half) else $error("serial clock too fast");
	property p_count; $rose(ss_n) |-> rise_r == 5'd16; endproperty
	a_count: assert property (p_count) else $error("frame clock count wrong");
	property p_mosi_par; $rose(ss_n) |-> mo_r[1] == ^mo_r[15:9] && mo_r[0] == ^mo_r[8:2]; endproperty
	a_mosi_par: assert property (p_mosi_par) else $error("host frame parity wrong");
	property p_miso_par; $rose(ss_n) |-> mi_r[1] == ^mi_r[15:9] && mi_r[0] == ^mi_r[8:2]; endproperty
	a_miso_par: assert property (p_miso_par) else $error("device frame parity wrong");
	property p_resv_zero; $rose(ss_n) && !echo_r |-> !mi_r[14]; endproperty
	a_resv_zero: assert property (p_resv_zero) else $error("reserved status bit set");
	property p_echo; $rose(ss_n) && echo_r |-> mi_r == cmd_r; endproperty
	a_echo: assert property (p_echo) else $error("write command not echoed");
	property p_release; ss_n [*8] |-> !miso_oe; endproperty
	a_release: assert property (p_release) else $error("miso driven while deselected");

	cover property ($rose(ss_n) && mo_r[15]);
	cover property ($rose(ss_n) && !mo_r[15]);
	cover property ($rose(ss_n) && mi_r[14:10] != 5'h00);
endmodule

// file: verification/test_spi_slave_bus_master_bridge.sv
/*
 * Bench: host end and device end on one link, a second device end
 * driven by hand for faults. Assumes a byte memory behind the bus.
 */
`timescale 1ns/100ps
module test_spi_slave_bus_master_bridge
	import spb_pkg::*;
;
	logic        ref_clk, sys_rst, spe, reg_wr, reg_rd, sclk_d, ss_d, req_d;
	logic        bus_req, bus_gnt, bus_rd, bus_wr, cpu_stall, pa_b;
	logic [1:0]  secure_lvl;
	logic [7:0]  reg_addr, bus_wdata, bus_rdata;
	logic [31:0] reg_wdata, reg_rdata, seed;
	logic [15:0] bus_addr, sho, shi, rb, fb;
	logic [4:0]  last_status, last_status_b;
	logic [12:0] cur_a;
	logic [7:0]  mem [0:8191];
	logic [7:0]  exp_m [0:8191];
	logic [15:0] qo[$], qi[$];
	int          fails, n_compared, n_acc;

	spb_link_if link ();
	spb_link_if link_b ();
	spb_host i_spb_host (.ref_clk, .sys_rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .link(link));
	spb_dev i_spb_dev (.ref_clk, .sys_rst, .clk_en(1'b1), .link(link), .serial_port_enable(spe),
		.memory_security_level(secure_lvl), .bus_req, .bus_gnt, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
		.bus_rdata, .cpu_stall, .port_active(), .last_status);
	spb_dev i_spb_dev_b (.ref_clk, .sys_rst, .clk_en(1'b1), .link(link_b), .serial_port_enable(spe),
		.memory_security_level(secure_lvl), .bus_req(), .bus_gnt(1'b0), .bus_addr(), .bus_rd(), .bus_wr(),
		.bus_wdata(), .bus_rdata(8'h00), .cpu_stall(), .port_active(pa_b), .last_status(last_status_b));
	spb_link_assertions i_spb_link_assertions (.ref_clk, .sys_rst, .sclk(link.sclk), .ss_n(link.ss_n),
		.mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [15:0] mkf(input logic [13:0] b);
		return {b, ^b[13:7], ^b[6:0]};
	endfunction
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Memory behind the device bus
	always @(posedge ref_clk) begin
		req_d <= bus_req;
		bus_gnt <= bus_req & req_d;
		bus_rdata <= bus_rd ? mem[bus_addr[12:0]] : ~bus_rdata;
		if (bus_wr) mem[bus_addr[12:0]] <= bus_wdata;
		if (bus_rd | bus_wr) begin
			n_acc++;
			check("bus_addr", bus_addr, {3'h0, cur_a});
			check("cpu_stall", 16'(cpu_stall), 16'h0001);
		end
	end
	// Frames seen on the link
	always @(posedge ref_clk) begin
		sclk_d <= link.sclk;
		ss_d <= link.ss_n;
		if (link.sclk & ~sclk_d) begin
			sho <= {sho[14:0], link.mosi};
			shi <= {shi[14:0], link.miso};
		end
		if (link.ss_n & ~ss_d) begin
			qo.push_back(sho);
			qi.push_back(shi);
		end
	end

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic txn(input logic w, input logic [12:0] a, input logic [7:0] d, input logic [4:0] es);
		logic [31:0] s;
		int k;
		if (!w) d = exp_m[a];
		else if (es == 5'h00) exp_m[a] = d;
		qo.delete();
		qi.delete();
		cur_a = a;
		n_acc = 0;
		wreg(HREG_ADDR, {19'h0, a});
		wreg(HREG_WDATA, {24'h0, d});
		wreg(HREG_CMD, w ? 32'h2 : 32'h1);
		s = 32'h1;
		for (k = 0; k < 3000 && s[0]; k++) rreg(HREG_STAT, s);
		check("busy", 16'(s[0]), 16'h0000);
		check("parity", 16'(s[6]), 16'h0000);
		check("status", 16'(s[5:1]), 16'(es));
		// Filler read frame carries no ignore flag
		check("last_status", 16'(last_status), 16'(es & 5'h17));
		check("cmd_frame", qo[0], mkf({w, a}));
		if (es != 5'h00) check("no_access", 16'(n_acc), 16'h0000);
		else begin
			check("data", 16'(s[15:8]), 16'(d));
			check("last_resp", qi[qi.size() - 1], mkf({w, 5'h00, d}));
			if (w) begin
				check("echo", qi[1], qo[0]);
				check("data_frame", 16'({qo[1][15], qo[1][9:2]}), 16'({1'b1, d}));
				check("memory", 16'(mem[a]), 16'(d));
			end
		end
	endtask
	task drive_b(input int n, input logic [15:0] f, output logic [15:0] r);
		@(posedge ref_clk);
		link_b.ss_n <= 1'b0;
		link_b.mosi <= f[15];
		repeat (n) begin
			repeat (8) @(posedge ref_clk);
			link_b.sclk <= 1'b1;
			r = {r[14:0], link_b.miso};
			repeat (8) @(posedge ref_clk);
			link_b.sclk <= 1'b0;
			f = f << 1;
			link_b.mosi <= f[15];
		end
		repeat (8) @(posedge ref_clk);
		check("port_active", 16'(pa_b), 16'h0001);
		link_b.ss_n <= 1'b1;
		link_b.mosi <= ~f[15];
		repeat (64) @(posedge ref_clk);
		check("port_idle", 16'(pa_b), 16'h0000);
	endtask

	initial begin
		sys_rst = 1'b1;
		{spe, secure_lvl, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{link_b.sclk, link_b.mosi} = 2'b00;
		{link_b.ss_n, link_b.enable_strap_pin_n} = 2'b11;
		seed = 32'hF915BEC1;
		fails = 0;
		n_compared = 0;
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 8'(i * 37);
			exp_m[i] = mem[i];
		end
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (600) @(posedge ref_clk);
		txn(1'b1, 13'h1FFF, 8'h3C, 5'h00);
		txn(1'b0, 13'h1FFF, 8'h00, 5'h00);
		txn(1'b0, 13'h0000, 8'h00, 5'h00);
		@(posedge ref_clk) spe <= 1'b1;
		repeat (20) begin
			seed = xs(seed);
			txn(seed[0], seed[13:1], seed[31:24], 5'h00);
		end
		@(posedge ref_clk) secure_lvl <= 2'b01;
		txn(1'b0, 13'h008F, 8'h00, 5'h00);
		txn(1'b0, 13'h0090, 8'h00, 5'h01);
		txn(1'b1, 13'h1800, 8'hA5, 5'h00);
		txn(1'b1, 13'h188F, 8'h5A, 5'h00);
		txn(1'b1, 13'h1890, 8'h11, 5'h09);
		@(posedge ref_clk) secure_lvl <= 2'b11;
		txn(1'b0, 13'h17FF, 8'h00, 5'h01);
		@(posedge ref_clk) secure_lvl <= 2'b00;
		// Second device end, bus never granted
		fb = mkf({1'b0, 13'h0040});
		drive_b(16, fb, rb);
		check("first_resp", 16'(rb[13]), 16'h0001);
		check("timeout", 16'(last_status_b), 16'h0001);
		drive_b(15, fb, rb);
		check("short_frame", 16'(last_status_b), 16'h000C);
		drive_b(17, fb, rb);
		check("long_frame", 16'(last_status_b), 16'h000C);
		drive_b(16, fb ^ 16'h0001, rb);
		check("bad_parity", 16'(last_status_b), 16'h0008);
		wrap_up;
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		fails++;
		wrap_up;
	end
endmodule
